//--- logic/csa_defs.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 100 MHz core clock
// Notes: included by the overcurrent timer and sense control files
`ifndef CSA_DEFS_SVH
`define CSA_DEFS_SVH
`define CSA_REG_OUTPUT_CONTROL 8'h11
`define CSA_REG_CHANNEL_CONFIGURATION 8'h12
`define CSA_REG_CONVERTER_RESULT 8'h21
`define CSA_OUTPUT_CONTROL_RST 8'h00
`define CSA_CHANNEL_CONFIGURATION_RST 8'h00
`define CSA_CONVERTER_RESULT_RST 8'h00
`define CSA_SEL_LSB 0
`define CSA_SEL_MSB 2
`define CSA_LATCH_LSB 3
`define CSA_LATCH_MSB 6
`define CSA_SEL_OFF 3'h0
`define CSA_SEL_CH0 3'h1
`define CSA_SEL_CH3 3'h4
`define CSA_SEL_EXT 3'h5
`define CSA_FORCE_LOW 8'h00
`define CSA_FORCE_HIGH 8'hff
`define CSA_UNMAPPED_READ 8'h00
`define CSA_CLK_MHZ 100
`define CSA_CONV_NS 12000
`define CSA_CONV_CYC ((`CSA_CONV_NS * `CSA_CLK_MHZ) / 1000)
`define CSA_BLANK_US 200
`define CSA_BLANK_CYC (`CSA_BLANK_US * `CSA_CLK_MHZ)
`define CSA_LATCH_SHORT_US 20
`define CSA_LATCH_SHORT_CYC (`CSA_LATCH_SHORT_US * `CSA_CLK_MHZ)
`define CSA_LATCH_LONG_MS 20
`define CSA_LATCH_LONG_CYC (`CSA_LATCH_LONG_MS * 1000 * `CSA_CLK_MHZ)
`endif

//--- logic/csa_pkg.sv
// Purpose: shared types of the sense converter control
// Assumes: constants come from csa_defs.svh
// Notes: types only
`default_nettype none
package csa_pkg;
    typedef logic [7:0] csa_byte_t;
    typedef logic [3:0] csa_chan_t;
    typedef enum logic [1:0] {CSA_IDLE, CSA_BLANK, CSA_CONVERT} csa_state_t;
endpackage : csa_pkg
`default_nettype wire

//--- logic/csa_overcurrent_limit_if.sv
// Purpose: carries overcurrent timer signals between control and timer
// Assumes: one clock domain
// Notes: control drives the inputs of the timer
`timescale 1ns/1ps
`default_nettype none
interface csa_overcurrent_limit_if;
    logic [3:0] limit_hit;
    logic [3:0] long_sel;
    logic [3:0] drive;
    logic [3:0] latch_evt;
    modport ctrl (output limit_hit, output long_sel, output drive,
        input latch_evt);
    modport timer (input limit_hit, input long_sel, input drive,
        output latch_evt);
endinterface : csa_overcurrent_limit_if
`default_nettype wire

//--- logic/csa_overcurrent_limit_timer.sv
// Purpose: per-channel overcurrent latch timers
// Assumes: limit_hit already synchronised
// Notes: a started timer runs to completion
`timescale 1ns/1ps
`default_nettype none
`include "csa_defs.svh"
module csa_overcurrent_limit_timer #(
    parameter int LONG_CYC = `CSA_LATCH_LONG_CYC
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    csa_overcurrent_limit_if.timer bus
);
    import csa_pkg::*;

    for (genvar gi = 0; gi < 4; gi++)
    begin : g_chan
        logic run;
        logic [20:0] cnt;
        logic [20:0] last;
        assign last = bus.long_sel[gi] ? 21'(LONG_CYC - 1)
                                       : 21'(`CSA_LATCH_SHORT_CYC - 1);
        always_ff @(posedge core_clk_in or posedge rst_in)
        begin
            if (rst_in)
            begin
                run <= 1'b0;
                cnt <= '0;
            end
            else if (run)
            begin
                if (cnt >= last)
                begin
                    run <= 1'b0;
                    cnt <= '0;
                end
                else
                begin
                    cnt <= cnt + 21'h1;
                end
            end
            else if (bus.limit_hit[gi] && bus.drive[gi])
            begin
                run <= 1'b1;
                cnt <= '0;
            end
        end
        // fault only if the current is still above the limit at expiry
        assign bus.latch_evt[gi] = run && (cnt >= last) &&
                                   bus.limit_hit[gi];

        early_latch_a: assert property (@(posedge core_clk_in)
            disable iff (rst_in)
            $rose(run) |-> !bus.latch_evt[gi] [*8])
            else $error("overcurrent fault before timer expiry");
    end
endmodule : csa_overcurrent_limit_timer
`default_nettype wire

//--- logic/csa_sense_ctrl.sv
// Purpose: control of the 8-bit current sense converter
// Assumes: adc_sample_in is the analog converter's code, valid on the
//   conversion-end strobe; fault comparators are asynchronous pins
// Notes: registers reached through a byte-wide register port
//
// What this block does
// - 8-bit result readable at result register
// - three-bit source select, zero disables all
// - codes one to five route channel or external input, six and seven disable
// - conversions repeat back to back, twelve microseconds
// - last result held during next conversion
// - shorted resistor gives zeros, open gives ones
// - external source with open pin undefined
// - reset reads zero, off channel keeps last
// - selected channel turning on blanks, reads zero
// - channel already on converts without blanking
// - first conversion only after blanking ends
// - overcurrent limiting forces all ones
// - latched-off overcurrent channel reads zero
// - external source after wake converts immediately
// - source change finishes current conversion first
// - disabled converter returns last result
// - read copies shadow into output buffer
// - battery-short shutdown keeps last value
// - overcurrent fault at timer expiry, channel off
`timescale 1ns/1ps
`default_nettype none
`include "csa_defs.svh"
module csa_sense_ctrl #(
    parameter int BLANK_CYC = `CSA_BLANK_CYC,
    parameter int LATCH_LONG_CYC = `CSA_LATCH_LONG_CYC
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire csa_pkg::csa_byte_t reg_wdata_in,
    input wire logic reg_rd_in,
    output csa_pkg::csa_byte_t reg_rdata_out,
    output logic reg_rdata_valid_out,
    input wire csa_pkg::csa_chan_t overcurrent_limit_in,
    input wire csa_pkg::csa_chan_t battery_short_in,
    input wire logic sense_short_in,
    input wire logic sense_open_in,
    input wire csa_pkg::csa_byte_t adc_sample_in,
    output csa_pkg::csa_chan_t channel_output_out,
    output logic [2:0] adc_source_out,
    output logic adc_sample_strobe_out
);
    import csa_pkg::*;

    localparam int ConvLast = `CSA_CONV_CYC - 1;
    localparam int BlankLast = BLANK_CYC - 1;

    function automatic logic is_chan(input logic [2:0] sel);
        is_chan = (sel >= `CSA_SEL_CH0) && (sel <= `CSA_SEL_CH3);
    endfunction : is_chan

    function automatic logic [1:0] chan_idx(input logic [2:0] sel);
        logic [2:0] off;
        off = sel - `CSA_SEL_CH0;
        chan_idx = off[1:0];
    endfunction : chan_idx

    function automatic logic is_live(input logic [2:0] sel);
        is_live = is_chan(sel) || (sel == `CSA_SEL_EXT);
    endfunction : is_live

    logic [9:0] pin_s1;
    logic [9:0] pin_s2;
    logic [9:0] pin_s3;
    logic [9:0] pin_f;
    csa_chan_t ocl_f;
    csa_chan_t stb_f;
    logic short_f;
    logic open_f;
    csa_byte_t out_ctrl;
    csa_byte_t cfg;
    csa_byte_t result;
    csa_chan_t overcurrent_limit_fault;
    csa_chan_t drive;
    csa_chan_t drive_q;
    csa_state_t state;
    logic [2:0] active_src;
    logic [14:0] cnt;
    logic [2:0] sel_now;
    logic src_ch;
    logic [1:0] ch;
    logic conv_end;
    logic blank_end;
    logic turn_on;
    csa_overcurrent_limit_if overcurrent_limit_bus ();

    // comparator pins: a change counts once stages two and three agree
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            pin_s1 <= '0;
            pin_s2 <= '0;
            pin_s3 <= '0;
            pin_f <= '0;
        end
        else
        begin
            pin_s1 <= {sense_open_in, sense_short_in, battery_short_in,
                       overcurrent_limit_in};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            pin_f <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 | pin_s3));
        end
    end
    assign ocl_f = pin_f[3:0];
    assign stb_f = pin_f[7:4];
    assign short_f = pin_f[8];
    assign open_f = pin_f[9];

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            out_ctrl <= `CSA_OUTPUT_CONTROL_RST;
            cfg <= `CSA_CHANNEL_CONFIGURATION_RST;
        end
        else if (reg_wr_in)
        begin
            if (reg_addr_in == `CSA_REG_OUTPUT_CONTROL)
                out_ctrl <= reg_wdata_in;
            if (reg_addr_in == `CSA_REG_CHANNEL_CONFIGURATION)
                cfg <= reg_wdata_in;
        end
    end

    // latched overcurrent fault; cleared by dropping the enable bit,
    // but a new fault in the same cycle wins
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            overcurrent_limit_fault <= '0;
        else
            overcurrent_limit_fault <= overcurrent_limit_bus.latch_evt |
                          (overcurrent_limit_fault & out_ctrl[3:0]);
    end

    assign drive = out_ctrl[3:0] & ~overcurrent_limit_fault & ~stb_f;
    assign channel_output_out = drive;

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            drive_q <= '0;
        else
            drive_q <= drive;
    end

    assign overcurrent_limit_bus.limit_hit = ocl_f;
    assign overcurrent_limit_bus.long_sel = cfg[`CSA_LATCH_MSB:`CSA_LATCH_LSB];
    assign overcurrent_limit_bus.drive = drive;

    csa_overcurrent_limit_timer #(
        .LONG_CYC(LATCH_LONG_CYC)
    ) u_timer (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .bus(overcurrent_limit_bus.timer)
    );

    assign sel_now = cfg[`CSA_SEL_MSB:`CSA_SEL_LSB];
    assign src_ch = is_chan(active_src);
    assign ch = chan_idx(active_src);
    assign conv_end = (state == CSA_CONVERT) && (cnt == 15'(ConvLast));
    assign blank_end = (state == CSA_BLANK) && (cnt == 15'(BlankLast));
    assign turn_on = (state == CSA_CONVERT) && src_ch && drive[ch] &&
                     !drive_q[ch];
    assign adc_sample_strobe_out = conv_end;
    assign adc_source_out = active_src;

    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            state <= CSA_IDLE;
            active_src <= `CSA_SEL_OFF;
            cnt <= '0;
        end
        else
        begin
            unique case (state)
                CSA_IDLE:
                begin
                    // an on channel or the external pin starts at once
                    if (is_live(sel_now))
                    begin
                        state <= CSA_CONVERT;
                        active_src <= sel_now;
                        cnt <= '0;
                    end
                end
                CSA_BLANK:
                begin
                    if (!is_live(sel_now))
                    begin
                        state <= CSA_IDLE;
                        active_src <= `CSA_SEL_OFF;
                        cnt <= '0;
                    end
                    else if (blank_end)
                    begin
                        state <= CSA_CONVERT;
                        active_src <= sel_now;
                        cnt <= '0;
                    end
                    else
                    begin
                        cnt <= cnt + 15'h1;
                    end
                end
                CSA_CONVERT:
                begin
                    if (!is_live(sel_now))
                    begin
                        state <= CSA_IDLE;
                        active_src <= `CSA_SEL_OFF;
                        cnt <= '0;
                    end
                    else if (turn_on)
                    begin
                        state <= CSA_BLANK;
                        cnt <= '0;
                    end
                    else if (conv_end)
                    begin
                        active_src <= sel_now;
                        cnt <= '0;
                    end
                    else
                    begin
                        cnt <= cnt + 15'h1;
                    end
                end
                default:
                begin
                    state <= CSA_IDLE;
                    active_src <= `CSA_SEL_OFF;
                    cnt <= '0;
                end
            endcase
        end
    end

    // shadow result: forced values first, then completed conversions
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
            result <= `CSA_CONVERTER_RESULT_RST;
        else if (state == CSA_BLANK)
            result <= `CSA_FORCE_LOW;
        else if (state == CSA_CONVERT && src_ch &&
                 overcurrent_limit_bus.latch_evt[ch])
            result <= `CSA_FORCE_LOW;
        else if (state == CSA_CONVERT && src_ch && drive[ch] && ocl_f[ch])
            result <= `CSA_FORCE_HIGH;
        else if (conv_end)
        begin
            if (src_ch)
            begin
                // an off channel keeps the last value sampled
                if (drive[ch])
                begin
                    if (short_f)
                        result <= `CSA_FORCE_LOW;
                    else if (open_f)
                        result <= `CSA_FORCE_HIGH;
                    else
                        result <= adc_sample_in;
                end
            end
            else if (short_f)
                result <= `CSA_FORCE_LOW;
            else
                result <= adc_sample_in;
        end
    end

    // register reads; the result read takes the shadow as it stands
    always_ff @(posedge core_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            reg_rdata_out <= '0;
            reg_rdata_valid_out <= 1'b0;
        end
        else
        begin
            reg_rdata_valid_out <= reg_rd_in;
            if (reg_rd_in)
            begin
                if (reg_addr_in == `CSA_REG_CONVERTER_RESULT)
                    reg_rdata_out <= result;
                else if (reg_addr_in == `CSA_REG_OUTPUT_CONTROL)
                    reg_rdata_out <= out_ctrl;
                else if (reg_addr_in == `CSA_REG_CHANNEL_CONFIGURATION)
                    reg_rdata_out <= cfg;
                else
                    reg_rdata_out <= `CSA_UNMAPPED_READ;
            end
        end
    end

    sequence blank_start_s;
        $rose(state == CSA_BLANK);
    endsequence

    sequence blank_hold_s;
        (state == CSA_BLANK) [*2];
    endsequence

    blank_zero_a: assert property (@(posedge core_clk_in)
        disable iff (rst_in)
        (state == CSA_BLANK) |=> (result == `CSA_FORCE_LOW))
        else $error("result not zero during blanking");

    blank_len_a: assert property (@(posedge core_clk_in)
        disable iff (rst_in)
        (state == CSA_BLANK && is_live(sel_now) && cnt < 15'(BlankLast))
        |-> blank_hold_s)
        else $error("blanking ended too early");

    no_early_a: assert property (@(posedge core_clk_in)
        disable iff (rst_in)
        blank_start_s |-> !adc_sample_strobe_out [*8])
        else $error("conversion ended inside blanking");

    overcurrent_limit_high_a: assert property (@(posedge core_clk_in)
        disable iff (rst_in)
        (state == CSA_CONVERT && src_ch && drive[ch] && ocl_f[ch] &&
         !overcurrent_limit_bus.latch_evt[ch]) |=> (result == `CSA_FORCE_HIGH))
        else $error("overcurrent did not force all ones");

    latch_low_a: assert property (@(posedge core_clk_in)
        disable iff (rst_in)
        (state == CSA_CONVERT && src_ch && overcurrent_limit_bus.latch_evt[ch])
        |=> (result == `CSA_FORCE_LOW) && !drive[$past(ch)])
        else $error("latched channel not reading zero");

    idle_hold_a: assert property (@(posedge core_clk_in)
        disable iff (rst_in)
        (state == CSA_IDLE) |=> $stable(result))
        else $error("result changed while disabled");

    ext_hold_a: assert property (@(posedge core_clk_in)
        disable iff (rst_in)
        (state == CSA_CONVERT && !src_ch && !conv_end) |=> $stable(result))
        else $error("result changed mid conversion");

    restart_a: assert property (@(posedge core_clk_in)
        disable iff (rst_in)
        (conv_end && !turn_on && is_live(sel_now)) |=>
        (state == CSA_CONVERT) && (cnt == 15'h0) &&
        (active_src == $past(sel_now)))
        else $error("conversion did not restart on new source");

    short_low_a: assert property (@(posedge core_clk_in)
        disable iff (rst_in)
        (conv_end && short_f && (!src_ch || drive[ch]) &&
         !(src_ch && ocl_f[ch])) |=> (result == `CSA_FORCE_LOW))
        else $error("shorted resistor did not force zeros");

    readout_a: assert property (@(posedge core_clk_in)
        disable iff (rst_in)
        (reg_rd_in && reg_addr_in == `CSA_REG_CONVERTER_RESULT) |=>
        reg_rdata_valid_out && (reg_rdata_out == $past(result)))
        else $error("readout differs from shadow");
endmodule : csa_sense_ctrl
`default_nettype wire

//--- dv/csa_afe_model.sv
// Purpose: converter front end as seen from the sense control block
// Assumes: the code follows the converted source and a bench bias
// Notes: an idle converter gives a code that changes every cycle
`timescale 1ns/1ps
`default_nettype none
module csa_afe_model (
    input wire logic core_clk_in,
    input wire logic [2:0] source_in,
    input wire logic [4:0] bias_in,
    output csa_pkg::csa_byte_t sample_out
);
    import csa_pkg::*;
    csa_byte_t spin = 8'h5a;
    always_ff @(posedge core_clk_in)
    begin
        spin <= spin + 8'h35;
    end
    // nothing meaningful is sampled while idle, so never hold a value
    assign sample_out = (source_in == 3'h0) ? spin : {source_in, bias_in};
endmodule : csa_afe_model
`default_nettype wire

//--- dv/test_csa_sense_ctrl.sv
// Purpose: self-checking bench of the sense converter control
// Assumes: short blanking and short long-latch counts for run time
// Notes: expected codes are source in the top bits, bias below
`timescale 1ns/1ps
`default_nettype none
module test_csa_sense_ctrl;
    import csa_pkg::*;
    localparam int BLANK = 40;
    localparam int CONV = 1200;
    logic core_clk_in;
    logic rst_in;
    logic [7:0] reg_addr_in;
    logic reg_wr_in;
    csa_byte_t reg_wdata_in;
    logic reg_rd_in;
    csa_byte_t reg_rdata_out;
    logic reg_rdata_valid_out;
    csa_chan_t overcurrent_limit_in;
    csa_chan_t battery_short_in;
    logic sense_short_in;
    logic sense_open_in;
    csa_byte_t adc_sample_in;
    csa_chan_t channel_output_out;
    logic [2:0] adc_source_out;
    logic adc_sample_strobe_out;
    logic [4:0] bias;
    int num_errors;
    int n_compared;
    int cyc;
    int lat;
    csa_byte_t rd;

    csa_sense_ctrl #(.BLANK_CYC(BLANK), .LATCH_LONG_CYC(100)) u_dut (
        .core_clk_in(core_clk_in), .rst_in(rst_in),
        .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
        .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out),
        .reg_rdata_valid_out(reg_rdata_valid_out),
        .overcurrent_limit_in(overcurrent_limit_in),
        .battery_short_in(battery_short_in),
        .sense_short_in(sense_short_in), .sense_open_in(sense_open_in),
        .adc_sample_in(adc_sample_in),
        .channel_output_out(channel_output_out),
        .adc_source_out(adc_source_out),
        .adc_sample_strobe_out(adc_sample_strobe_out)
    );

    csa_afe_model u_afe (
        .core_clk_in(core_clk_in), .source_in(adc_source_out),
        .bias_in(bias), .sample_out(adc_sample_in)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR t=%0t seen=%0h expected=%0h", $time, seen, exp);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] a, input csa_byte_t d);
        @(posedge core_clk_in);
        #1;
        reg_addr_in = a;
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(posedge core_clk_in);
        #1;
        reg_wr_in = 1'b0;
    endtask : reg_write

    task automatic rd_expect(input logic [7:0] a, input csa_byte_t e);
        @(posedge core_clk_in);
        #1;
        reg_addr_in = a;
        reg_rd_in = 1'b1;
        @(posedge core_clk_in);
        #1;
        reg_rd_in = 1'b0;
        check(reg_rdata_valid_out, 1'b1);
        rd = reg_rdata_out;
        check(rd, e);
    endtask : rd_expect

    // leaves the bench one step after the edge that opens the strobe cycle
    task automatic wait_strobe(output int n);
        @(posedge core_clk_in);
        #1;
        n = 1;
        while (adc_sample_strobe_out !== 1'b1 && n < 30000)
        begin
            @(posedge core_clk_in);
            #1;
            n++;
        end
        if (adc_sample_strobe_out !== 1'b1)
            num_errors++;
    endtask : wait_strobe

    task automatic conclude;
        $display("compared=%0d errors=%0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : conclude

    initial
    begin
        core_clk_in = 1'b0;
        forever #5 core_clk_in = ~core_clk_in;
    end

    initial
    begin
        #600000;
        num_errors++;
        conclude();
    end

    initial
    begin
        rst_in = 1'b1;
        reg_addr_in = 8'h00;
        reg_wr_in = 1'b0;
        reg_wdata_in = 8'h00;
        reg_rd_in = 1'b0;
        overcurrent_limit_in = 4'h0;
        battery_short_in = 4'h0;
        sense_short_in = 1'b0;
        sense_open_in = 1'b0;
        bias = 5'h0a;
        num_errors = 0;
        n_compared = 0;
        repeat (12) @(posedge core_clk_in);
        #1;
        rst_in = 1'b0;
        rd_expect(8'h21, 8'h00);
        rd_expect(8'h12, 8'h00);
        rd_expect(8'h33, 8'h00);
        check(adc_source_out, 3'h0);
        reg_write(8'h12, 8'h05);
        @(posedge core_clk_in);
        #1;
        check(adc_source_out, 3'h5);
        wait_strobe(cyc);
        check(cyc <= CONV, 1'b1);
        rd_expect(8'h21, 8'haa);
        bias = 5'h13;
        rd_expect(8'h21, 8'haa);
        wait_strobe(cyc);
        wait_strobe(cyc);
        check(cyc, CONV);
        reg_write(8'h21, 8'h5a);
        rd_expect(8'h21, 8'hb3);
        reg_write(8'h12, 8'h01);
        check(adc_source_out, 3'h5);
        wait_strobe(cyc);
        @(posedge core_clk_in);
        #1;
        check(adc_source_out, 3'h1);
        bias = 5'h07;
        wait_strobe(cyc);
        rd_expect(8'h21, 8'hb3);
        reg_write(8'h11, 8'h01);
        check(channel_output_out, 4'h1);
        // blanking is entered one edge after the drive rises
        @(posedge core_clk_in);
        rd_expect(8'h21, 8'h00);
        wait_strobe(cyc);
        check(cyc > CONV, 1'b1);
        rd_expect(8'h21, 8'h27);
        reg_write(8'h11, 8'h00);
        // long latch first: its fault must come long before the short one
        for (int k = 0; k < 2; k++)
        begin
            lat = (k == 0) ? 100 : 2000;
            reg_write(8'h12, (k == 0) ? 8'h09 : 8'h01);
            reg_write(8'h11, 8'h01);
            repeat (BLANK + 10) @(posedge core_clk_in);
            #1;
            overcurrent_limit_in = 4'h1;
            repeat (8) @(posedge core_clk_in);
            rd_expect(8'h21, 8'hff);
            repeat (lat - 20) @(posedge core_clk_in);
            #1;
            check(channel_output_out, 4'h1);
            repeat (40) @(posedge core_clk_in);
            #1;
            check(channel_output_out, 4'h0);
            rd_expect(8'h21, 8'h00);
            overcurrent_limit_in = 4'h0;
            reg_write(8'h11, 8'h00);
        end
        reg_write(8'h12, 8'h00);
        reg_write(8'h11, 8'h02);
        reg_write(8'h12, 8'h02);
        @(posedge core_clk_in);
        #1;
        check(adc_source_out, 3'h2);
        wait_strobe(cyc);
        check(cyc <= CONV, 1'b1);
        rd_expect(8'h21, 8'h47);
        sense_short_in = 1'b1;
        wait_strobe(cyc);
        rd_expect(8'h21, 8'h00);
        sense_short_in = 1'b0;
        sense_open_in = 1'b1;
        wait_strobe(cyc);
        rd_expect(8'h21, 8'hff);
        sense_open_in = 1'b0;
        wait_strobe(cyc);
        rd_expect(8'h21, 8'h47);
        battery_short_in = 4'h2;
        repeat (6) @(posedge core_clk_in);
        #1;
        check(channel_output_out, 4'h0);
        bias = 5'h1c;
        wait_strobe(cyc);
        rd_expect(8'h21, 8'h47);
        reg_write(8'h12, 8'h00);
        @(posedge core_clk_in);
        #1;
        check(adc_source_out, 3'h0);
        battery_short_in = 4'h0;
        repeat (CONV + 10) @(posedge core_clk_in);
        rd_expect(8'h21, 8'h47);
        // host side readback of the output control register against the channel drive
        rd_expect(8'h11, 8'h02);
        check(channel_output_out, 4'h2);
        conclude();
    end
endmodule : test_csa_sense_ctrl
`default_nettype wire
